// ---- src/dis_pkg.sv ----
/*
 * Shared constants and types for the display intensity shifter.
 * Assumes a single 50 MHz system clock; all times are in nanoseconds.
 */
package dis_pkg;

    // ------------------------------------------------------------
    // Word and timer widths
    // ------------------------------------------------------------
    localparam int WORD_W = 12;
    localparam int TW     = 12;

    // ------------------------------------------------------------
    // Timing, as printed and as cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 20;
    localparam int T_SETUP_SHORT_NS   = 4800;
    localparam int T_SETUP_LONG_NS    = 6400;
    localparam int T_SETTLE_NS        = 25000;
    localparam int T_DARK_NS          = 1000;
    localparam int T_LIT_NS           = 3000;
    localparam int T_PULSE_NS         = 500;

    localparam logic [TW-1:0] SETUP_SHORT_CYC =
        TW'((T_SETUP_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] SETUP_LONG_CYC  =
        TW'((T_SETUP_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] SETTLE_CYC      =
        TW'((T_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] DARK_CYC        =
        TW'((T_DARK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] LIT_CYC         =
        TW'((T_LIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TW-1:0] PULSE_CYC       =
        TW'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Operand values and channel select bits
    // ------------------------------------------------------------
    localparam logic [0:WORD_W-1] WORD_ZERO   = 12'h000;
    localparam logic [0:WORD_W-1] SINGLE_POINT = 12'h001;
    localparam int                TEST_BIT    = 11;
    localparam int                CH_FIRST    = 0;
    localparam int                CH_SECOND   = 1;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DIS_IDLE   = 3'b000,
        DIS_SETUP  = 3'b001,
        DIS_ARM    = 3'b010,
        DIS_SETTLE = 3'b011,
        DIS_DWELL  = 3'b100
    } dis_state_t;

endpackage : dis_pkg

// ---- src/dis_timer.sv ----
/*
 * Down-counting interval timer.
 * A start loads a length of N cycles; running is high for the next N cycles
 * and tick marks the last of them. A start during a run restarts it.
 */
`timescale 1ns/10ps
module dis_timer #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    // Status
    output logic              running,
    output logic              tick
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         run_d;

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (start) begin
            cnt_d = len - 1'b1;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q == '0) begin
                run_d = 1'b0;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end

    assign running = run_q;
    assign tick    = run_q && (cnt_q == '0);

endmodule : dis_timer

// ---- src/dis_shifter.sv ----
/*
 * Intensification shifter of a point-plot display controller.
 * Assumes the instruction strobes, operand and selects are synchronous to
 * clk_sys and that coordinate registers live outside and follow coord_adv.
 */
`timescale 1ns/10ps

module dis_shifter (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    // Instruction side
    input  wire logic                        character_display_instr,
    input  wire logic                        point_display_instr,
    input  wire logic [0:dis_pkg::WORD_W-1]  pattern,
    input  wire logic                        setup_long,
    input  wire logic [1:0]                  chan_sel,
    // Display control and timing
    input  wire logic                        start_pulse,
    // Status
    output logic                             busy,
    output logic                             armed,
    output logic                             done,
    // Display side
    output logic                             coord_adv,
    output logic                             intens_first,
    output logic                             intens_second
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dis_pkg::dis_state_t          st_q;
    dis_pkg::dis_state_t          st_d;
    logic [0:dis_pkg::WORD_W-1]   shift_q;
    logic [0:dis_pkg::WORD_W-1]   shift_d;
    logic [0:dis_pkg::WORD_W-1]   cur;
    logic [1:0]                   chan_q;
    logic [1:0]                   chan_d;
    logic                         slong_q;
    logic                         slong_d;
    logic                         done_q;
    logic                         done_d;
    logic                         adv_q;
    logic                         adv_d;
    logic                         ph_start;
    logic [dis_pkg::TW-1:0]       ph_len;
    logic                         ph_tick;
    logic                         pulse_start;
    logic                         pulse_run;
    logic                         accept;

    assign accept = (st_q == dis_pkg::DIS_IDLE)
                    && (character_display_instr || point_display_instr);

    // The word a step looks at: in dwell it is the word after the shift.
    assign cur = (st_q == dis_pkg::DIS_DWELL) ? {1'b0, shift_q[0:10]} : shift_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        shift_d     = shift_q;
        chan_d      = chan_q;
        slong_d     = slong_q;
        done_d      = 1'b0;
        adv_d       = 1'b0;
        ph_start    = 1'b0;
        ph_len      = dis_pkg::SETUP_SHORT_CYC;
        pulse_start = 1'b0;
        case (st_q)
            dis_pkg::DIS_IDLE: begin
                if (accept) begin
                    // Character pattern wins if both strobes coincide.
                    if (character_display_instr) begin
                        shift_d = pattern;
                    end else begin
                        shift_d = dis_pkg::SINGLE_POINT;
                    end
                    chan_d   = chan_sel;
                    slong_d  = setup_long;
                    ph_start = 1'b1;
                    ph_len   = setup_long ? dis_pkg::SETUP_LONG_CYC
                                          : dis_pkg::SETUP_SHORT_CYC;
                    st_d     = dis_pkg::DIS_SETUP;
                end
            end
            dis_pkg::DIS_SETUP: begin
                if (ph_tick) begin
                    st_d = dis_pkg::DIS_ARM;
                end
            end
            dis_pkg::DIS_ARM: begin
                // A start pulse seen before setup ends is not remembered.
                if (start_pulse) begin
                    ph_start = 1'b1;
                    ph_len   = dis_pkg::SETTLE_CYC;
                    st_d     = dis_pkg::DIS_SETTLE;
                end
            end
            dis_pkg::DIS_SETTLE, dis_pkg::DIS_DWELL: begin
                if (ph_tick) begin
                    shift_d = cur;
                    if (cur == dis_pkg::WORD_ZERO) begin
                        st_d   = dis_pkg::DIS_IDLE;
                        done_d = 1'b1;
                    end else begin
                        st_d        = dis_pkg::DIS_DWELL;
                        ph_start    = 1'b1;
                        ph_len      = cur[dis_pkg::TEST_BIT] ? dis_pkg::LIT_CYC
                                                            : dis_pkg::DARK_CYC;
                        pulse_start = cur[dis_pkg::TEST_BIT];
                        // Coordinates only move when another point follows.
                        adv_d       = (st_q == dis_pkg::DIS_DWELL);
                    end
                end
            end
            default: begin
                st_d = dis_pkg::DIS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q    <= dis_pkg::DIS_IDLE;
            shift_q <= dis_pkg::WORD_ZERO;
            chan_q  <= 2'h0;
            slong_q <= 1'b0;
            done_q  <= 1'b0;
            adv_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            shift_q <= shift_d;
            chan_q  <= chan_d;
            slong_q <= slong_d;
            done_q  <= done_d;
            adv_q   <= adv_d;
        end
    end

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    dis_timer #(.W(dis_pkg::TW)) u_phase (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (ph_start),
        .len     (ph_len),
        .running (),
        .tick    (ph_tick)
    );

    dis_timer #(.W(dis_pkg::TW)) u_pulse (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (pulse_start),
        .len     (dis_pkg::PULSE_CYC),
        .running (pulse_run),
        .tick    ()
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign busy          = (st_q != dis_pkg::DIS_IDLE);
    assign armed         = (st_q == dis_pkg::DIS_ARM);
    assign done          = done_q;
    assign coord_adv     = adv_q;
    assign intens_first  = pulse_run && chan_q[dis_pkg::CH_FIRST];
    assign intens_second = pulse_run && chan_q[dis_pkg::CH_SECOND];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    localparam int PULSE_N = int'(dis_pkg::PULSE_CYC);

    logic [dis_pkg::TW-1:0] ph_cnt_q;
    logic [dis_pkg::TW-1:0] hi_cnt_q;
    logic [dis_pkg::TW-1:0] ph_exp_q;
    logic                   lit_pt_q;
    logic [1:0]             sel_acc_q;
    logic                   chr_op_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ph_cnt_q <= '0;
            hi_cnt_q <= '0;
            ph_exp_q <= '0;
        end else begin
            // The first cycle of a phase counts as one, so a phase of N cycles ends at N.
            ph_cnt_q <= ph_start ? {{(dis_pkg::TW-1){1'b0}}, 1'b1} : ph_cnt_q + 1'b1;
            hi_cnt_q <= pulse_run ? hi_cnt_q + 1'b1 : '0;
            ph_exp_q <= ph_start ? ph_len : ph_exp_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lit_pt_q  <= 1'b0;
            sel_acc_q <= 2'h0;
            chr_op_q  <= 1'b0;
        end else begin
            if (ph_start) begin
                lit_pt_q <= pulse_start;
            end
            if (accept) begin
                sel_acc_q <= chan_sel;
                chr_op_q  <= character_display_instr;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_hold_for_start: assert property ((st_q == dis_pkg::DIS_ARM) && !start_pulse
        |=> (st_q == dis_pkg::DIS_ARM) && !pulse_run)
        else $error("scan left arm state without a start pulse");
    a_point_load: assert property (accept && !character_display_instr
        |=> shift_q == dis_pkg::SINGLE_POINT)
        else $error("point instruction did not load a single point");
    a_char_load: assert property (accept && character_display_instr
        |=> shift_q == $past(pattern))
        else $error("character pattern not copied into shift register");
    a_test_bit: assert property (ph_tick && (cur != dis_pkg::WORD_ZERO) && busy
        && (st_q != dis_pkg::DIS_SETUP) |=> pulse_run == $past(cur[dis_pkg::TEST_BIT]))
        else $error("intensify pulse does not match bit 11");
    a_pulse_width: assert property ($fell(pulse_run) |-> hi_cnt_q == PULSE_N)
        else $error("intensify pulse width wrong");
    a_shift_step: assert property ((st_q == dis_pkg::DIS_DWELL) && ph_tick
        |=> shift_q == {1'b0, $past(shift_q[0:10])})
        else $error("register did not shift right by one");
    a_end_on_zero: assert property (done |-> !busy && shift_q == dis_pkg::WORD_ZERO
        && !pulse_run)
        else $error("completion with bits still set or a pulse running");
    a_chan_route: assert property (pulse_run |-> (intens_first == sel_acc_q[0])
        && (intens_second == sel_acc_q[1]))
        else $error("intensify pulse on wrong channel");
    a_setup_time: assert property ((st_q == dis_pkg::DIS_SETUP) && ph_tick
        |-> ph_cnt_q == (slong_q ? dis_pkg::SETUP_LONG_CYC : dis_pkg::SETUP_SHORT_CYC))
        else $error("setup interval wrong");
    a_settle_time: assert property ((st_q == dis_pkg::DIS_SETTLE) && ph_tick
        |-> ph_cnt_q == dis_pkg::SETTLE_CYC)
        else $error("settling interval wrong");
    a_point_time: assert property ((st_q == dis_pkg::DIS_DWELL) && ph_tick
        |-> ph_cnt_q == (lit_pt_q ? dis_pkg::LIT_CYC : dis_pkg::DARK_CYC)
        && ph_exp_q == ph_cnt_q)
        else $error("point dwell time wrong");
    a_no_late_move: assert property (coord_adv |-> shift_q != dis_pkg::WORD_ZERO)
        else $error("coordinates moved past the last point");
    a_zero_operand: assert property ((st_q == dis_pkg::DIS_SETTLE) && ph_tick
        && (shift_q == dis_pkg::WORD_ZERO) |=> done && !pulse_run)
        else $error("zero operand did not finish after settling");

    c_char_done: cover property (done && chr_op_q);
    c_point_done: cover property (done && !chr_op_q);
    c_zero_done: cover property ((st_q == dis_pkg::DIS_SETTLE) && ph_tick
        && (shift_q == dis_pkg::WORD_ZERO));
    c_both_chan: cover property (intens_first && intens_second);

endmodule : dis_shifter

// ---- bench/dis_crt_model.sv ----
/*
 * Behavioural model of one point-plot display driven by the shifter.
 * Assumes intens and coord_adv are synchronous to clk_sys and held low in reset.
 */
`timescale 1ns/10ps
module dis_crt_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Beam control
    input wire logic intens,
    input wire logic coord_adv
);
    // ------------------------------------------------------------
    // Spot log
    // ------------------------------------------------------------
    // A step in the same cycle as a rising beam counts before the spot, so a
    // late step after the last lit spot is always visible to the bench.
    int   n_pulse;
    int   n_adv;
    int   adv_at_lit;
    int   width;
    int   last_width;
    logic lit_q;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            n_pulse    <= 0;
            n_adv      <= 0;
            adv_at_lit <= 0;
            width      <= 0;
            last_width <= 0;
            lit_q      <= 1'b0;
        end else begin
            lit_q <= intens;
            if (coord_adv) begin
                n_adv <= n_adv + 1;
            end
            if (intens && !lit_q) begin
                n_pulse    <= n_pulse + 1;
                adv_at_lit <= n_adv + (coord_adv ? 1 : 0);
                width      <= 1;
            end else if (intens) begin
                width <= width + 1;
            end else if (lit_q) begin
                last_width <= width;
            end
        end
    end
endmodule : dis_crt_model

// ---- bench/dis_shifter_bench.sv ----
/*
 * Self-checking bench for the display intensity shifter.
 * Assumes the design package, the shifter and the display model are compiled first.
 */
`timescale 1ns/10ps
module dis_shifter_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                        clk_sys;
    logic                        rst_n;
    logic                        character_display_instr;
    logic                        point_display_instr;
    logic [0:dis_pkg::WORD_W-1]  pattern;
    logic                        setup_long;
    logic [1:0]                  chan_sel;
    logic                        start_pulse;
    logic                        busy;
    logic                        armed;
    logic                        done;
    logic                        coord_adv;
    logic                        intens_first;
    logic                        intens_second;
    int                          n_fail;
    int                          n_checks;
    int                          cyc_cnt;

    dis_shifter dis_shifter_i (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .character_display_instr(character_display_instr),
        .point_display_instr(point_display_instr), .pattern(pattern),
        .setup_long(setup_long), .chan_sel(chan_sel), .start_pulse(start_pulse),
        .busy(busy), .armed(armed), .done(done), .coord_adv(coord_adv),
        .intens_first(intens_first), .intens_second(intens_second)
    );
    dis_crt_model dis_crt_model_i0 (
        .clk_sys(clk_sys), .rst_n(rst_n), .intens(intens_first), .coord_adv(coord_adv)
    );
    dis_crt_model dis_crt_model_i1 (
        .clk_sys(clk_sys), .rst_n(rst_n), .intens(intens_second), .coord_adv(coord_adv)
    );

    // ------------------------------------------------------------
    // Clock, timeout and report
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            n_fail = n_fail + 1;
            results();
        end
    end

    task automatic results();
        if (n_fail == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // ------------------------------------------------------------
    // One display operation, with expectations built from the word
    // ------------------------------------------------------------
    // Start is pulsed while idle and during setup, a strobe is sent while
    // busy, and the operands change after accept: all of it must be ignored.
    task automatic op(input logic chr, input logic [0:dis_pkg::WORD_W-1] pat,
                      input logic lng, input logic [1:0] sel);
        logic [0:dis_pkg::WORD_W-1] w;
        int d, np, na, s;
        w = chr ? pat : dis_pkg::SINGLE_POINT;
        d = 0;
        np = 0;
        na = -1;
        while (w !== dis_pkg::WORD_ZERO) begin
            d += w[dis_pkg::TEST_BIT] ? int'(dis_pkg::LIT_CYC) : int'(dis_pkg::DARK_CYC);
            np += int'(w[dis_pkg::TEST_BIT]);
            na++;
            w = w >> 1;
        end
        if (na < 0) na = 0;
        s = lng ? int'(dis_pkg::SETUP_LONG_CYC) : int'(dis_pkg::SETUP_SHORT_CYC);
        rst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        start_pulse = 1'b1;
        @(negedge clk_sys);
        character_display_instr = chr;
        point_display_instr = !chr;
        pattern = pat;
        setup_long = lng;
        chan_sel = sel;
        start_pulse = 1'b0;
        @(negedge clk_sys);
        character_display_instr = 1'b0;
        point_display_instr = 1'b0;
        pattern = '1;
        setup_long = !lng;
        chan_sel = ~sel;
        start_pulse = 1'b1;
        @(negedge clk_sys);
        start_pulse = 1'b0;
        chk(busy, 1);
        repeat (s - 2) @(negedge clk_sys);
        chk(armed, 0);
        @(negedge clk_sys);
        chk(armed, 1);
        start_pulse = 1'b1;
        @(negedge clk_sys);
        start_pulse = 1'b0;
        point_display_instr = 1'b1;
        @(negedge clk_sys);
        point_display_instr = 1'b0;
        chk(armed, 0);
        repeat (int'(dis_pkg::SETTLE_CYC) - 2 + d) @(negedge clk_sys);
        chk(done, 0);
        @(negedge clk_sys);
        chk(done, 1);
        chk(busy, 0);
        @(negedge clk_sys);
        chk(done, 0);
        chk(busy, 0);
        chk(dis_crt_model_i0.n_pulse, sel[0] ? np : 0);
        chk(dis_crt_model_i1.n_pulse, sel[1] ? np : 0);
        chk(dis_crt_model_i0.n_adv, na);
        if (np > 0 && sel[0]) begin
            chk(dis_crt_model_i0.last_width, dis_pkg::PULSE_CYC);
            chk(dis_crt_model_i0.adv_at_lit, dis_crt_model_i0.n_adv);
        end
        if (np > 0 && sel[1]) begin
            chk(dis_crt_model_i1.last_width, dis_pkg::PULSE_CYC);
            chk(dis_crt_model_i1.adv_at_lit, dis_crt_model_i1.n_adv);
        end
    endtask : op

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_point_full_word();
        op(1'b0, 12'hfff, 1'b0, 2'b01);
    endtask : t_point_full_word

    task automatic t_char_long_both();
        op(1'b1, 12'h805, 1'b1, 2'b11);
    endtask : t_char_long_both

    task automatic t_char_trailing_dark();
        op(1'b1, 12'h006, 1'b0, 2'b10);
    endtask : t_char_trailing_dark

    task automatic t_char_no_channel();
        op(1'b1, 12'hfff, 1'b0, 2'b00);
    endtask : t_char_no_channel

    task automatic t_zero_word();
        op(1'b1, 12'h000, 1'b1, 2'b11);
    endtask : t_zero_word

    initial begin
        rst_n = 1'b0;
        character_display_instr = 1'b0;
        point_display_instr = 1'b0;
        pattern = 12'h000;
        setup_long = 1'b0;
        chan_sel = 2'b00;
        start_pulse = 1'b0;
        n_fail = 0;
        n_checks = 0;
        cyc_cnt = 0;
        t_point_full_word();
        t_char_long_both();
        t_char_trailing_dark();
        t_char_no_channel();
        t_zero_word();
        results();
    end
endmodule : dis_shifter_bench
